// ### psa_pkg.sv
/*
  Package for the power stage auxiliary control block: register map, field
  positions, reset values and enumerations.
  Assumes an APB slave with 32-bit data, one aligned word per register.
*/
`default_nettype none

package psa_pkg;

  // Register byte offsets (one word per controller where per-stage)
  localparam logic [7:0] CTRL0_OFF    = 8'h00;  // Stage control, stage 0
  localparam logic [7:0] CTRL1_OFF    = 8'h04;  // Stage control, stage 1
  localparam logic [7:0] CTRL2_OFF    = 8'h08;  // Stage control, stage 2
  localparam logic [7:0] CFG0_OFF     = 8'h10;  // Stage config, stage 0
  localparam logic [7:0] CFG1_OFF     = 8'h14;  // Stage config, stage 1
  localparam logic [7:0] CFG2_OFF     = 8'h18;  // Stage config, stage 2
  localparam logic [7:0] SYNCOUT_OFF  = 8'h20;  // Sync/output config, stage 2 view
  localparam logic [7:0] MATRIX_OFF   = 8'h24;  // Output matrix values
  localparam logic [7:0] RCMPA_OFF    = 8'h28;  // Reset compare A, shared by all stages
  localparam logic [7:0] RCMPB_OFF    = 8'h2c;  // Reset compare B, shared by all stages
  localparam logic [7:0] CAPT_OFF     = 8'h30;  // Capture time, stage 2
  localparam logic [7:0] IRQ_OFF      = 8'h34;  // Flags (read) / clear (write 1)
  localparam logic [7:0] VEC_OFF      = 8'h38;  // Lowest pending vector address (highest priority)

  // Stage control fields
  localparam int CTL_RUN     = 0;   // Run bit
  localparam int CTL_ARUN    = 1;   // Autorun follow bit
  localparam int CTL_PRE_LO  = 2;   // Prescale select, low
  localparam int CTL_PRE_HI  = 3;   // Prescale select, high

  // Stage config fields
  localparam int CFG_CLKSEL  = 0;   // Clock source select
  localparam int CFG_MODE_LO = 1;   // Running mode, 2 bits
  localparam int CFG_IMODE_LO = 3;  // Input mode, 4 bits
  localparam int CFG_POL     = 7;   // Output polarity bit
  localparam int CFG_MATRIX  = 8;   // Output matrix enable
  localparam int CFG_IEN_EC  = 9;   // End-of-cycle interrupt enable
  localparam int CFG_IEN_CAP = 10;  // Capture interrupt enable
  localparam int CFG_FLTEN   = 11;  // Fault input enable

  // Sync/output config fields
  localparam int SO_SYNC_LO  = 4;   // ADC sync select, low
  localparam int SO_SYNC_HI  = 5;   // ADC sync select, high
  localparam int SO_SEL1     = 6;   // Extra output 1 select
  localparam int SO_SEL2     = 7;   // Extra output 2 select

  localparam logic [31:0] RESET_VAL = 32'h0000_0000;

  // Input mode numbers that this block reacts to
  localparam logic [3:0] IMODE_HALT  = 4'h7;
  localparam logic [3:0] IMODE_BLANK = 4'he;

  // Vector addresses
  localparam logic [3:0] VEC_NONE = 4'h0;
  localparam logic [3:0] VEC_BASE = 4'h1;

  // Counter width
  localparam int CNT_W = 12;

  // Running modes
  typedef enum logic [1:0] {
    MODE_ONE_RAMP,
    MODE_TWO_RAMP,
    MODE_FOUR_RAMP,
    MODE_CENTERED
  } psa_mode_e;

endpackage : psa_pkg

`default_nettype wire

// ### psa_aux_ctrl.sv
/*
  Auxiliary control for three chained power stage controllers: run chain,
  fault back-propagation, prescaler, ramp counters, mode 14 blanking,
  capture, output matrix, extra output selectors, ADC sync and vectors.
  Assumes an APB master on clk, and retrigger/fault pins from outside.
*/
//
// Operation
// - Mode 14 blanks output, ramp continues
// - Old variant: accept event only in on-time
// - Stage 2 input event latches counter into capture
// - New capture always overwrites old value
// - Four-ramp matrix drives per-ramp output bits
// - Matrix active: polarity ignored
// - Extra out 1: A, or B when set
// - Extra out 2: B, or A when set
// - ADC sync pulse from chosen edge
// - Centered: compare A times sync, min 1
// - Interrupts on reload and input
// - Two vectors: end-of-cycle and capture
// - Vectors 1..6, capture first, stage 2 first
// - Autorun stage starts with predecessor
// - Chained stages share aligned periods
// - Mode 7 faults travel both chain directions
// - Dropping run stops a follower whose own run bit is clear
// - Clock select and divide 1,4,16,64
// - B variant divides 1,4,32,256
// - Sync encoding: A lead/trail, B lead/trail
`timescale 1ns/1ps
`default_nettype none

module psa_aux_ctrl #(
  parameter bit B_VARIANT = 1'b0,  // Selects the wider prescaler divides
  parameter int NSTAGE    = 3      // Number of chained stages
) (
  input  wire logic        clk,
  input  wire logic        srst,
  input  wire logic        clkPllEn,     // One-cycle enable from the PLL clock path
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic [2:0]  faultIn,      // Retrigger/fault pin per stage
  output logic      [2:0]  mainOutA,
  output logic      [2:0]  mainOutB,
  output logic             stage2ExtraOut1,
  output logic             stage2ExtraOut2,
  output logic      [2:0]  adcSync,      // One-cycle pulse per stage
  output logic      [2:0]  endOfCycleIrq,
  output logic      [2:0]  captureEventIrq,
  output logic      [3:0]  vectorAddr
);

  // Per-stage registers
  logic [3:0]          ctrl_ff [NSTAGE];    // Stage control
  logic [11:0]         cfg_ff  [NSTAGE];    // Stage config
  logic [7:0]          syncOut_ff;          // Sync/output config
  logic [7:0]          matrix_ff;           // A ramp0..3 in [3:0], B in [7:4]
  logic [11:0]         rcmpA_ff;            // Reset compare A
  logic [11:0]         rcmpB_ff;            // Reset compare B
  logic [11:0]         capt_ff;             // Capture time of stage 2
  logic [NSTAGE-1:0]   ecFlag_ff;           // End-of-cycle flags
  logic [NSTAGE-1:0]   capFlag_ff;          // Capture flags
  logic [11:0]         cnt_ff  [NSTAGE];    // Ramp counters
  logic [1:0]          ramp_ff [NSTAGE];    // Ramp number
  logic [7:0]          pre_ff  [NSTAGE];    // Prescale counters
  logic [2:0]          f1_ff, f2_ff, f3_ff; // Pin synchroniser
  logic [2:0]          flt_ff;              // Agreed filtered level
  logic [2:0]          effRun;              // Effective run per stage
  logic [2:0]          fltHalt;             // Halt from own or chained fault
  logic [2:0]          tick;                // Stage clock enable
  logic [2:0]          rawA, rawB;          // Waveform before blanking
  logic [2:0]          outA, outB;          // Final outputs
  logic [2:0]          prevA_ff, prevB_ff;  // Edge detect of outputs
  logic [2:0]          fltRise;             // Input event
  logic [2:0]          reload;              // End of ramp cycle
  logic [2:0]          blankAcc_ff;         // Mode 14 event taken for this blank
  logic [2:0]          fltOwn;              // Enabled mode 7 fault of the stage itself
  logic [2:0]          fltBack;             // Own fault plus faults handed back
  // The matrix owns stage 2 only while it runs four ramps
  wire                 matrixOn = cfg_ff[2][psa_pkg::CFG_MATRIX] &&
                                  (cfg_ff[2][2:1] == psa_pkg::MODE_FOUR_RAMP);

  // APB decode
  wire        apbWr   = psel & penable & pwrite;
  wire        apbRd   = psel & penable & ~pwrite;
  wire [7:0]  addr    = paddr;
  wire        hitCtrl = (addr == psa_pkg::CTRL0_OFF) | (addr == psa_pkg::CTRL1_OFF)
                      | (addr == psa_pkg::CTRL2_OFF);
  wire        hitCfg  = (addr == psa_pkg::CFG0_OFF) | (addr == psa_pkg::CFG1_OFF)
                      | (addr == psa_pkg::CFG2_OFF);
  wire [1:0]  sIdx    = addr[3:2];
  wire        mapped  = hitCtrl | hitCfg | (addr == psa_pkg::SYNCOUT_OFF)
                      | (addr == psa_pkg::MATRIX_OFF) | (addr == psa_pkg::RCMPA_OFF)
                      | (addr == psa_pkg::RCMPB_OFF) | (addr == psa_pkg::CAPT_OFF)
                      | (addr == psa_pkg::IRQ_OFF) | (addr == psa_pkg::VEC_OFF);

  // Zero-wait slave; unmapped addresses answer with an error
  assign pready  = 1'b1;
  assign pslverr = psel & penable & ~mapped;

  // Read mux
  always_comb begin
    prdata = psa_pkg::RESET_VAL;
    if (apbRd) begin
      if (hitCtrl) prdata = {28'h0, ctrl_ff[sIdx]};
      else if (hitCfg) prdata = {20'h0, cfg_ff[sIdx]};
      else case (addr)
        psa_pkg::SYNCOUT_OFF: prdata = {24'h0, syncOut_ff};
        psa_pkg::MATRIX_OFF:  prdata = {24'h0, matrix_ff};
        psa_pkg::RCMPA_OFF:   prdata = {20'h0, rcmpA_ff};
        psa_pkg::RCMPB_OFF:   prdata = {20'h0, rcmpB_ff};
        psa_pkg::CAPT_OFF:    prdata = {20'h0, capt_ff};
        psa_pkg::IRQ_OFF:     prdata = {26'h0, capFlag_ff, ecFlag_ff};
        psa_pkg::VEC_OFF:     prdata = {28'h0, vectorAddr};
        default:              prdata = psa_pkg::RESET_VAL;
      endcase
    end
  end

  // Config register writes; a halting fault clears the run bit
  always_ff @(posedge clk) begin
    if (srst) begin
      for (int i = 0; i < NSTAGE; i++) begin
        ctrl_ff[i] <= 4'h0;
        cfg_ff[i]  <= 12'h000;
      end
      syncOut_ff <= 8'h00;
      matrix_ff  <= 8'h00;
      rcmpA_ff   <= 12'h001;
      rcmpB_ff   <= 12'h000;
    end else begin
      for (int i = 0; i < NSTAGE; i++) begin
        if (apbWr && hitCtrl && sIdx == 2'(i)) ctrl_ff[i] <= pwdata[3:0];
        else if (fltHalt[i]) ctrl_ff[i][psa_pkg::CTL_RUN] <= 1'b0;
        if (apbWr && hitCfg && sIdx == 2'(i)) cfg_ff[i] <= pwdata[11:0];
      end
      if (apbWr && addr == psa_pkg::SYNCOUT_OFF) syncOut_ff <= pwdata[7:0];
      if (apbWr && addr == psa_pkg::MATRIX_OFF)  matrix_ff  <= pwdata[7:0];
      if (apbWr && addr == psa_pkg::RCMPA_OFF)   rcmpA_ff   <= pwdata[11:0];
      if (apbWr && addr == psa_pkg::RCMPB_OFF)   rcmpB_ff   <= pwdata[11:0];
    end
  end

  // Pin synchroniser: a change counts once stages two and three agree
  always_ff @(posedge clk) begin
    if (srst) begin
      f1_ff <= 3'b000; f2_ff <= 3'b000; f3_ff <= 3'b000; flt_ff <= 3'b000;
    end else begin
      f1_ff <= faultIn;
      f2_ff <= f1_ff;
      f3_ff <= f2_ff;
      for (int i = 0; i < NSTAGE; i++)
        if (f2_ff[i] == f3_ff[i]) flt_ff[i] <= f3_ff[i];
    end
  end

  // Per-stage combinational logic
  always_comb begin
    for (int i = 0; i < NSTAGE; i++) begin
      // Autorun follows predecessor's effective run
      if (i > 0 && ctrl_ff[i][psa_pkg::CTL_ARUN])
        effRun[i] = effRun[i-1] | ctrl_ff[i][psa_pkg::CTL_RUN];
      else
        effRun[i] = ctrl_ff[i][psa_pkg::CTL_RUN];
      // Prescale divide from clock source and two-bit field
      tick[i] = (cfg_ff[i][psa_pkg::CFG_CLKSEL] ? clkPllEn : 1'b1) &&
        (ctrl_ff[i][psa_pkg::CTL_PRE_HI:psa_pkg::CTL_PRE_LO] == 2'd0 ? 1'b1 :
         ctrl_ff[i][psa_pkg::CTL_PRE_HI:psa_pkg::CTL_PRE_LO] == 2'd1 ? pre_ff[i][1:0] == 2'd3 :
         ctrl_ff[i][psa_pkg::CTL_PRE_HI:psa_pkg::CTL_PRE_LO] == 2'd2 ?
           (B_VARIANT ? pre_ff[i][4:0] == 5'h1f : pre_ff[i][3:0] == 4'hf) :
           (B_VARIANT ? pre_ff[i] == 8'hff : pre_ff[i][5:0] == 6'h3f));
      // A rise counts only once both late synchroniser stages agree on it,
      // so a one-cycle glitch on the pin never captures or flags
      fltRise[i] = f2_ff[i] & f3_ff[i] & ~flt_ff[i];
      // Shared compare B sets period, compare A splits on-times
      reload[i] = effRun[i] & tick[i] & (cnt_ff[i] >= rcmpB_ff);
      rawA[i] = effRun[i] & (cnt_ff[i] < rcmpA_ff);
      rawB[i] = effRun[i] & (cnt_ff[i] >= rcmpA_ff);
      // Mode 14: blank while input active, counter keeps running
      outA[i] = rawA[i];
      outB[i] = rawB[i];
      // Old variant blanks only when the event was taken in on-time
      if (cfg_ff[i][6:3] == psa_pkg::IMODE_BLANK && flt_ff[i] &&
          (B_VARIANT || blankAcc_ff[i])) begin
        outA[i] = 1'b0;
        outB[i] = 1'b0;
      end
      // Polarity inverts unless the matrix owns the outputs
      if (cfg_ff[i][psa_pkg::CFG_POL] && !(i == 2 && matrixOn)) begin
        outA[i] = ~outA[i];
        outB[i] = ~outB[i];
      end
    end
    // Matrix drives stage 2 per ramp in four-ramp mode
    if (matrixOn) begin
      outA[2] = matrix_ff[ramp_ff[2]];
      outB[2] = matrix_ff[3'd4 + 3'(ramp_ff[2])];
    end
    // Only mode 7 faults may stop a stage; other modes stay local
    for (int i = 0; i < NSTAGE; i++) begin
      fltOwn[i] = flt_ff[i] & cfg_ff[i][psa_pkg::CFG_FLTEN] &
                  (cfg_ff[i][6:3] == psa_pkg::IMODE_HALT);
    end
    // Backward pass: a follower hands its fault to its predecessor
    fltBack[NSTAGE-1] = fltOwn[NSTAGE-1];
    for (int i = NSTAGE - 2; i >= 0; i--) begin
      fltBack[i] = fltOwn[i] | (fltBack[i+1] & ctrl_ff[i+1][psa_pkg::CTL_ARUN]);
    end
    // Forward pass: a predecessor's fault also stops its follower
    // Two passes cover the whole chained group without a combinational loop
    fltHalt[0] = fltBack[0];
    for (int i = 1; i < NSTAGE; i++) begin
      fltHalt[i] = fltBack[i] | (fltHalt[i-1] & ctrl_ff[i][psa_pkg::CTL_ARUN]);
    end
  end

  // Counters, prescalers and output registers
  always_ff @(posedge clk) begin
    if (srst) begin
      for (int i = 0; i < NSTAGE; i++) begin
        cnt_ff[i] <= 12'h000; ramp_ff[i] <= 2'd0; pre_ff[i] <= 8'h00;
      end
      mainOutA <= 3'b000; mainOutB <= 3'b000;
      prevA_ff <= 3'b000; prevB_ff <= 3'b000;
    end else begin
      for (int i = 0; i < NSTAGE; i++) begin
        if (!effRun[i]) begin
          cnt_ff[i] <= 12'h000; ramp_ff[i] <= 2'd0; pre_ff[i] <= 8'h00;
        end else begin
          if (!cfg_ff[i][psa_pkg::CFG_CLKSEL] || clkPllEn) pre_ff[i] <= pre_ff[i] + 8'h01;
          if (reload[i]) begin
            cnt_ff[i]  <= 12'h000;
            ramp_ff[i] <= ramp_ff[i] + 2'd1;
          end else if (tick[i]) cnt_ff[i] <= cnt_ff[i] + 12'h001;
        end
      end
      mainOutA <= outA;
      mainOutB <= outB;
      prevA_ff <= mainOutA;
      prevB_ff <= mainOutB;
    end
  end

  // Extra outputs copy main outputs of stage 2
  assign stage2ExtraOut1 = syncOut_ff[psa_pkg::SO_SEL1] ? mainOutB[2] : mainOutA[2];
  assign stage2ExtraOut2 = syncOut_ff[psa_pkg::SO_SEL2] ? mainOutA[2] : mainOutB[2];

  // ADC sync: ramp modes use edges, centered uses compare A match
  wire [1:0] syncSel = syncOut_ff[psa_pkg::SO_SYNC_HI:psa_pkg::SO_SYNC_LO];
  always_comb begin
    for (int i = 0; i < NSTAGE; i++) begin
      if (cfg_ff[i][2:1] == psa_pkg::MODE_CENTERED)
        adcSync[i] = ~syncSel[1] & effRun[i] & tick[i] & (cnt_ff[i] == rcmpA_ff);
      else case (syncSel)
        2'd0:    adcSync[i] = mainOutA[i] & ~prevA_ff[i];
        2'd1:    adcSync[i] = ~mainOutA[i] & prevA_ff[i];
        2'd2:    adcSync[i] = mainOutB[i] & ~prevB_ff[i];
        default: adcSync[i] = ~mainOutB[i] & prevB_ff[i];
      endcase
    end
  end

  // Mode 14 event acceptance per stage
  // On-time here is any part of a running ramp, as this block has no
  // dead time; an event taken while stopped is ignored until the next rise
  always_ff @(posedge clk) begin
    if (srst) begin
      blankAcc_ff <= 3'b000;
    end else begin
      for (int i = 0; i < NSTAGE; i++) begin
        if (fltRise[i]) begin
          blankAcc_ff[i] <= rawA[i] | rawB[i];  // Decided once per rise
        end else if (!flt_ff[i]) begin
          blankAcc_ff[i] <= 1'b0;  // Pin released, forget the event
        end
      end
    end
  end

  // Capture and flags; set wins over software clear
  wire irqClr = apbWr & (addr == psa_pkg::IRQ_OFF);
  always_ff @(posedge clk) begin
    if (srst) begin
      capt_ff <= 12'h000; ecFlag_ff <= 3'b000; capFlag_ff <= 3'b000;
    end else begin
      if (fltRise[2]) capt_ff <= cnt_ff[2];
      for (int i = 0; i < NSTAGE; i++) begin
        if (reload[i]) ecFlag_ff[i] <= 1'b1;
        else if (irqClr && pwdata[i]) ecFlag_ff[i] <= 1'b0;
        if (fltRise[i]) capFlag_ff[i] <= 1'b1;
        else if (irqClr && pwdata[3+i]) capFlag_ff[i] <= 1'b0;
      end
    end
  end

  // Enabled requests per vector
  always_comb begin
    for (int i = 0; i < NSTAGE; i++) begin
      endOfCycleIrq[i]   = ecFlag_ff[i] & cfg_ff[i][psa_pkg::CFG_IEN_EC];
      captureEventIrq[i] = capFlag_ff[i] & cfg_ff[i][psa_pkg::CFG_IEN_CAP];
    end
  end

  // Vector order: stage 2 capture at 1 up to stage 0 end-of-cycle at 6
  always_comb begin
    vectorAddr = psa_pkg::VEC_NONE;
    for (int i = 0; i < NSTAGE; i++) begin
      if (endOfCycleIrq[i])   vectorAddr = psa_pkg::VEC_BASE + 4'(2*(2-i)) + 4'd1;
      if (captureEventIrq[i]) vectorAddr = psa_pkg::VEC_BASE + 4'(2*(2-i));
    end
  end

  // Stage 2 capture vector sits at the lowest address
  vec_order_a: assert property (@(posedge clk) disable iff (srst)
    captureEventIrq[2] |-> vectorAddr == 4'h1) else $error("vector order wrong");
  // Extra outputs copy main output A in the same cycle whenever they select it
  extra_sel_a: assert property (@(posedge clk) disable iff (srst)
    !syncOut_ff[psa_pkg::SO_SEL1] |-> stage2ExtraOut1 == mainOutA[2])
    else $error("extra out 1 mismatch");
  extra_two_a: assert property (@(posedge clk) disable iff (srst)
    syncOut_ff[psa_pkg::SO_SEL2] |-> stage2ExtraOut2 == mainOutA[2])
    else $error("extra out 2 mismatch");
  // Capture register takes the counter value of the rise cycle
  capt_load_a: assert property (@(posedge clk) disable iff (srst)
    fltRise[2] |=> capt_ff == $past(cnt_ff[2])) else $error("capture missed");
  // Flags are set the cycle after their event
  ec_flag_a: assert property (@(posedge clk) disable iff (srst)
    reload[0] |=> ecFlag_ff[0]) else $error("end flag not set");
  cap_flag_a: assert property (@(posedge clk) disable iff (srst)
    fltRise[2] |=> capFlag_ff[2]) else $error("capture flag not set");
  // A taken mode 14 event blanks the output on the next edge
  blank_out_a: assert property (@(posedge clk) disable iff (srst)
    (cfg_ff[0][6:3] == 4'he && flt_ff[0] && !cfg_ff[0][7] && (B_VARIANT || blankAcc_ff[0]))
    |=> !mainOutB[0]) else $error("blanking failed");
  blank_take_a: assert property (@(posedge clk) disable iff (srst)
    (cfg_ff[2][6:3] == 4'he && flt_ff[2] && blankAcc_ff[2] && !cfg_ff[2][7] && !matrixOn)
    |=> !mainOutA[2]) else $error("taken event not blanked");
  // A chained fault clears the run bit unless software writes it again
  halt_run_a: assert property (@(posedge clk) disable iff (srst)
    fltHalt[1] && !(apbWr && hitCtrl) |=> !ctrl_ff[1][0]) else $error("halt ignored");
  follow_run_a: assert property (@(posedge clk) disable iff (srst)
    ctrl_ff[1][1] && effRun[0] |-> effRun[1]) else $error("autorun lag");

endmodule : psa_aux_ctrl

`default_nettype wire

// ### psa_fault_src.sv
/*
  Far-side model of the retrigger and fault sensing that feeds the three
  stage input pins of the power stage auxiliary block.
  Assumes the bench requests an event with a one-cycle pulse on clk.
*/
`timescale 1ns/1ps
`default_nettype none

module psa_fault_src (
  input  wire logic       clk,
  input  wire logic       srst,
  input  wire logic [2:0] evtReq,   // Start an event on these pins
  input  wire logic [7:0] holdLen,  // Active cycles of each event
  output logic      [2:0] faultIn   // Active high level to the block
);
  logic [7:0] left_ff [3];  // Remaining active cycles per pin

  // Hold each pin active for the requested length, then release it
  always_ff @(posedge clk) begin
    for (int i = 0; i < 3; i++) begin
      if (srst) begin
        left_ff[i] <= 8'h00;
      end else if (evtReq[i]) begin
        left_ff[i] <= holdLen;  // A new event restarts the level
      end else if (left_ff[i] != 8'h00) begin
        left_ff[i] <= left_ff[i] - 8'h01;
      end
    end
  end

  // The sensor drives low between events, so the pin never floats
  always_comb begin
    for (int i = 0; i < 3; i++) begin
      faultIn[i] = (left_ff[i] != 8'h00);
    end
  end
endmodule // psa_fault_src

`default_nettype wire

// ### testbench.sv
/*
  Self-checking bench: register model, selectors, ADC sync, prescaler,
  matrix, blanking, capture, vectors and the run chain.
  Assumes a zero-wait APB slave and the fault source model on the pins.
*/
`timescale 1ns/1ps
`default_nettype none

module testbench;
  localparam int TMO = 60000;  // Cycle ceiling, well above the planned run
  // Register addresses: ctrl0..2, cfg0..2, syncout, matrix, rcmpA/B, capt, irq, vec
  localparam logic [7:0] ADR [13] = '{psa_pkg::CTRL0_OFF, psa_pkg::CTRL1_OFF,
    psa_pkg::CTRL2_OFF, psa_pkg::CFG0_OFF, psa_pkg::CFG1_OFF, psa_pkg::CFG2_OFF,
    psa_pkg::SYNCOUT_OFF, psa_pkg::MATRIX_OFF, psa_pkg::RCMPA_OFF, psa_pkg::RCMPB_OFF,
    psa_pkg::CAPT_OFF, psa_pkg::IRQ_OFF, psa_pkg::VEC_OFF};
  // Writable bits per register; status registers keep no written value
  localparam logic [31:0] MSK [13] = '{32'hf, 32'hf, 32'hf, 32'hfff, 32'hfff, 32'hfff,
    32'hff, 32'hff, 32'hfff, 32'hfff, 32'h0, 32'h0, 32'h0};
  logic        clk, srst;            // Clock, reset
  logic        clkPllEn = 1'b1;      // PLL enable, full rate until the first edge
  logic        psel, penable, pwrite;  // APB request
  logic [7:0]  paddr;                // APB address
  logic [31:0] pwdata, prdata, rdv;  // APB data, last read value
  logic        pready, pslverr, err;  // APB answer, last error
  logic [2:0]  faultIn, mainOutA, mainOutB, adcSync, ecIrq, capIrq, evtReq;
  logic [7:0]  holdLen;              // Event length in cycles
  logic        ext1, ext2;           // Extra stage 2 outputs
  logic [3:0]  vectorAddr;           // Pending vector
  logic [31:0] c1;                   // First captured count
  int          error_cnt, checks, ne, np, ne0;
  int          cyc = 0;              // Cycles since start, for the ceiling
  int          mdl [13];             // Register model

  psa_aux_ctrl #(.B_VARIANT(1'b0), .NSTAGE(3)) dut_u (.clk(clk), .srst(srst),
    .clkPllEn(clkPllEn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .faultIn(faultIn), .mainOutA(mainOutA), .mainOutB(mainOutB),
    .stage2ExtraOut1(ext1), .stage2ExtraOut2(ext2), .adcSync(adcSync),
    .endOfCycleIrq(ecIrq), .captureEventIrq(capIrq), .vectorAddr(vectorAddr));
  psa_fault_src src_u (.clk(clk), .srst(srst), .evtReq(evtReq), .holdLen(holdLen),
    .faultIn(faultIn));

  // 200 MHz clock
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  // Hang guard and random PLL enable, which only matters on the PLL source
  always @(posedge clk) begin
    cyc <= cyc + 1;
    clkPllEn <= 1'($urandom);
    if (cyc == TMO) begin
      error_cnt++;
      final_report();
    end
  end

  task automatic chk(input string nm, input logic [31:0] ex, input logic [31:0] got);
    checks++;
    if (got !== ex) begin
      error_cnt++;
      $display("CHECK FAILED %s expected %h seen %h", nm, ex, got);
    end
  endtask

  // One APB transfer; the request stands until pready is seen high
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
    end while (pready !== 1'b1);  // Only the cycle ceiling ends a stuck wait
    rdv = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);  // Idle edge keeps drivers single per time step
  endtask

  task automatic wr(input int i, input logic [31:0] d);
    apb(1'b1, ADR[i], d);
    mdl[i] = int'(d & MSK[i]);
  endtask

  task automatic rd(input int i, input string nm);
    apb(1'b0, ADR[i], 32'h0);
    chk(nm, 32'(mdl[i]), rdv);
  endtask

  function automatic logic sig(input int s);  // 0..2 output A, 4..6 output B
    return s < 4 ? mainOutA[s] : mainOutB[s - 4];
  endfunction

  // Count chosen edges and ADC sync pulses; extra outputs checked every cycle
  task automatic edges(input int n, input int s, input logic fall, output int e, output int p);
    logic prv;
    logic cur;
    logic [7:0] so;
    e = 0;
    p = 0;
    so = 8'(mdl[6]);
    prv = sig(s);
    repeat (n) begin
      @(posedge clk);
      cur = sig(s);
      if (cur != prv && cur == !fall) e++;
      if (adcSync[2] === 1'b1) p++;
      prv = cur;
      chk("extra out1", {31'h0, so[psa_pkg::SO_SEL1] ? mainOutB[2] : mainOutA[2]}, {31'h0, ext1});
      chk("extra out2", {31'h0, so[psa_pkg::SO_SEL2] ? mainOutA[2] : mainOutB[2]}, {31'h0, ext2});
    end
  endtask

  task automatic hold(input int n, input logic a, input logic b);
    repeat (n) begin
      @(posedge clk);
      chk("stage2 outputs", {30'h0, a, b}, {30'h0, mainOutA[2], mainOutB[2]});
    end
  endtask

  task automatic event_on(input logic [2:0] m);
    evtReq <= m;
    @(posedge clk);
    evtReq <= 3'h0;
  endtask

  task automatic final_report();
    $display("Comparisons %0d, mismatches %0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  initial begin
    void'($urandom(32'h54234d1b));
    {srst, psel, penable, pwrite, paddr, pwdata} = {3'b100, 1'b0, 8'h0, 32'h0};
    {evtReq, holdLen, error_cnt, checks} = {3'h0, 8'd40, 64'h0};
    foreach (mdl[i]) mdl[i] = 0;
    mdl[8] = 1;  // Compare A leaves reset at one
    repeat (20) @(posedge clk);
    srst <= 1'b0;
    foreach (ADR[i]) rd(i, "reset value");
    apb(1'b0, 8'h3c, 32'h0);
    chk("unmapped error", 32'h1, {31'h0, err});
    chk("unmapped data", 32'h0, rdv);
    repeat (8) begin
      ne = 6 + int'($urandom % 4);
      wr(ne, $urandom);
      rd(ne, "readback");
    end
    wr(8, 32'h8);  // Compare A kept at one or above
    wr(9, 32'h10);
    wr(5, 32'h2);  // Stage 2 two-ramp, no input mode
    wr(2, 32'h1);
    // Every sync source and every selector pairing
    for (int k = 0; k < 16; k++) begin
      wr(6, 32'(k) << 4);
      edges(300, k[1] ? 6 : 2, k[0], ne, np);
      chk("adc sync pulses", 32'h1, {31'h0, ne > 2 && (ne - np) inside {[-1:1]}});
    end
    // Each prescale step stretches the ramp by its divide
    for (int k = 0; k < 4; k++) begin
      wr(2, 32'h1 | (32'(k) << 2));
      edges(400 << (2 * k), 2, 1'b0, ne, np);
      if (k == 0) ne0 = ne;
      chk("prescale edges", 32'h1, {31'h0, ne0 > 2 && (ne - ne0) inside {[-1:1]}});
    end
    wr(2, 32'h1);
    // Centered mode: compare A match gives one pulse per 17-cycle ramp
    wr(5, 32'h26);  // Centered, input mode 4 only
    wr(6, 32'h00);
    edges(170, 2, 1'b0, ne, np);
    chk("centered sync", 32'd10, 32'(np));
    wr(6, 32'h20);  // Selector 10 sends no pulse in centered mode
    edges(170, 2, 1'b0, ne, np);
    chk("centered no sync", 32'd0, 32'(np));
    wr(7, 32'h0f);
    wr(5, 32'h104);
    repeat (20) @(posedge clk);
    hold(60, 1'b1, 1'b0);
    wr(5, 32'h184);
    hold(60, 1'b1, 1'b0);
    wr(5, 32'hc72);  // Mode 14, capture and fault enabled
    wr(3, 32'hc72);
    wr(11, 32'h3f);
    wr(0, 32'h1);
    event_on(3'b100);
    repeat (8) @(posedge clk);
    hold(25, 1'b0, 1'b0);
    repeat (20) @(posedge clk);
    chk("capture irq", 32'h1, {31'h0, capIrq[2]});
    chk("vector", 32'h1, {28'h0, vectorAddr});
    apb(1'b0, ADR[10], 32'h0);
    c1 = rdv;
    chk("capture range", 32'h1, {31'h0, c1 <= 32'h10});
    event_on(3'b001);
    repeat (60) @(posedge clk);
    chk("vector", 32'h1, {28'h0, vectorAddr});
    wr(11, 32'h20);
    chk("vector", 32'h5, {28'h0, vectorAddr});
    repeat (7) @(posedge clk);
    event_on(3'b100);
    repeat (60) @(posedge clk);
    apb(1'b0, ADR[10], 32'h0);
    chk("capture overwritten", 32'h1, {31'h0, rdv != c1});
    wr(11, 32'h3f);
    wr(5, 32'he72);
    repeat (100) @(posedge clk);
    chk("end of cycle irq", 32'h1, {31'h0, ecIrq[2]});
    chk("vector", 32'h2, {28'h0, vectorAddr});
    // Chain: only stage 1 follows, never all three
    wr(0, 32'h0);
    wr(3, 32'h2);
    wr(4, 32'h83a);  // Stage 1 mode 7 with fault enabled
    wr(1, 32'h2);
    wr(0, 32'h1);
    edges(200, 1, 1'b0, ne, np);
    chk("follower runs", 32'h1, {31'h0, ne > 0});
    wr(0, 32'h0);
    repeat (30) @(posedge clk);
    edges(200, 1, 1'b0, ne, np);
    chk("follower stopped", 32'h0, 32'(ne));
    wr(0, 32'h1);
    event_on(3'b010);
    repeat (60) @(posedge clk);
    mdl[0] = 0;
    rd(0, "fault stops master");
    final_report();
  end
endmodule // testbench

`default_nettype wire
